/* File: cogc_chk.sv */
// Port checker for the output generator top module.
// Assumes one pclk domain and a zero-wait APB slave.
`timescale 1ns/1ns
module cogc_chk (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire cogc_pkg::cogc_pins_t pins
);
  logic [7:0] con0;
  logic [7:0] con1;
  logic       acc;
  logic       wr_c0;
  logic       rd_c0;
  logic       rd_c1;
  assign acc = psel && penable;
  assign wr_c0 = acc && pwrite && paddr == cogc_pkg::OFF_CON0;
  assign rd_c0 = acc && !pwrite && paddr == cogc_pkg::OFF_CON0;
  assign rd_c1 = acc && !pwrite && paddr == cogc_pkg::OFF_CON1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con0 <= 8'h00;
      con1 <= 8'h00;
    end else if (acc && pwrite) begin
      if (paddr == cogc_pkg::OFF_CON0) con0 <= pwdata[7:0];
      if (paddr == cogc_pkg::OFF_CON1) con1 <= pwdata[7:0] & 8'hcf;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_now_a: assert property (acc |-> pready) else $error("ready low");
  unmapped_refused_a: assert property (acc && paddr > cogc_pkg::OFF_STATUS |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  ctl0_read_a: assert property (rd_c0 |-> prdata[5] == 1'b0 && prdata[7] == con0[7] &&
    prdata[4:0] == con0[4:0] && prdata[31:8] == 24'h0) else $error("ctl0 read");
  ctl1_read_a: assert property (rd_c1 |-> prdata == {24'h0, con1}) else $error("ctl1");
  ld_self_clear_a: assert property (rd_c0 && !con0[7] && !$past(wr_c0, 2) |->
    !prdata[6]) else $error("load flag stuck");
  off_no_drive_a: assert property (!con0[7] [*3] |-> pins.oe == 4'h0) else $error("oe");
  off_level_a: assert property ((!con0[7] && $stable(con1)) [*3] |->
    pins.level == con1[3:0]) else $error("idle level");
  rsvd_inactive_a: assert property ((con0[7] && (con0[4:3] == 2'b11 ||
    con0[2:1] == 2'b11) && $stable(con1)) [*3] |-> pins.oe == 4'hf &&
    pins.level == con1[3:0]) else $error("reserved drive");
  cover property (rd_c0 && prdata[6]);
  cover property (con0[7] && pins.oe == 4'hf);
  cover property (acc && pslverr);
endmodule : cogc_chk
bind cogc_core cogc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .pins);

/* File: cogc_clk_tick.sv */
// Module clock tick selector of the output generator.
// Assumes fast_tick is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ns
module cogc_clk_tick (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] sel,
  input  wire logic       fast_tick,
  output logic            tick
);

  logic [1:0] div_cnt;
  logic       div_tick;

  assign div_tick = (div_cnt == 2'(cogc_pkg::FOSC4_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // The reserved code yields no tick; the core's clr then holds every timed stage cleared.
  always_comb begin
    case (sel)
      cogc_pkg::CS_FOSC:  tick = 1'b1;
      cogc_pkg::CS_FOSC4: tick = div_tick;
      cogc_pkg::CS_FAST:  tick = fast_tick;
      default:            tick = 1'b0;
    endcase
  end

endmodule : cogc_clk_tick

/* File: cogc_core.sv */
// Complementary output generator: control registers, buffering and outputs.
// Assumes APB master on pclk and event inputs as one-cycle synchronous pulses.
`timescale 1ns/1ns
module cogc_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fast_osc_tick,
  input  wire logic        rise_event,
  input  wire logic        fall_event,
  input  wire logic        shutdown_in_n,
  output cogc_pkg::cogc_pins_t pins
);

  localparam int CW = cogc_pkg::COUNT_W;

  // ****************************************
  // Register state
  // ****************************************
  logic                    module_enable_flag;
  logic                    buffer_load_request;
  logic [1:0]              clock_source_field;
  logic [2:0]              output_mode_field;
  logic                    rise_deadband_source;
  logic                    fall_deadband_source;
  logic [3:0]              out_polarity;
  cogc_pkg::cogc_counts_t  cnt_reg;
  cogc_pkg::cogc_counts_t  cnt_buf;
  logic                    shutdown_active_flag;
  logic                    auto_restart_enable;
  logic [1:0]              ovr_ac;
  logic [1:0]              ovr_bd;
  logic                    sd_input_en;
  logic [3:0]              steer_en;
  logic [3:0]              static_level;
  cogc_pkg::cogc_ld_state_t ld_state;
  cogc_pkg::cogc_ld_state_t next_ld_state;

  // ****************************************
  // APB decode
  // ****************************************
  logic wr;
  logic rd_setup;
  logic hit_con0;
  logic hit_con1;
  logic hit_rph;
  logic hit_fph;
  logic hit_rbl;
  logic hit_fbl;
  logic hit_rdb;
  logic hit_fdb;
  logic hit_sd;
  logic hit_str;
  logic hit_sts;
  logic hit_any;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;

  assign hit_con0 = (paddr == cogc_pkg::OFF_CON0);
  assign hit_con1 = (paddr == cogc_pkg::OFF_CON1);
  assign hit_rph  = (paddr == cogc_pkg::OFF_RPHASE);
  assign hit_fph  = (paddr == cogc_pkg::OFF_FPHASE);
  assign hit_rbl  = (paddr == cogc_pkg::OFF_RBLANK);
  assign hit_fbl  = (paddr == cogc_pkg::OFF_FBLANK);
  assign hit_rdb  = (paddr == cogc_pkg::OFF_RDB);
  assign hit_fdb  = (paddr == cogc_pkg::OFF_FDB);
  assign hit_sd   = (paddr == cogc_pkg::OFF_SDCTL);
  assign hit_str  = (paddr == cogc_pkg::OFF_STEER);
  assign hit_sts  = (paddr == cogc_pkg::OFF_STATUS);
  assign hit_any  = hit_con0 | hit_con1 | hit_rph | hit_fph | hit_rbl
                  | hit_fbl | hit_rdb | hit_fdb | hit_sd | hit_str | hit_sts;

  assign wr       = psel & penable & pwrite & hit_any;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wbyte    = pwdata[7:0];

  // Zero wait states; the read word is registered in the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ****************************************
  // Waveform state and events
  // ****************************************
  logic       mod_tick;
  logic       bad_cfg;
  logic       run;
  logic       drive;
  logic       drive_q;
  logic       drive_rise;
  logic       drive_fall;
  logic       a_on;
  logic       b_on;
  logic       pp_phase;
  logic [3:0] steer_act;
  logic       sd_src;
  logic       sd_hold;
  logic       rise_ok;
  logic       fall_ok;
  logic       rph_done;
  logic       fph_done;
  logic       rbl_busy;
  logic       fbl_busy;
  logic       rdb_done;
  logic       fdb_done;
  logic       ld_xfer;
  logic       ld_clear;

  // Reserved encodings mark the configuration unusable.
  assign bad_cfg = (clock_source_field == cogc_pkg::CS_RSVD)
                 | (output_mode_field[2:1] == 2'b11);
  assign run     = module_enable_flag & ~bad_cfg;

  // Blanking of one edge masks the opposite event.
  assign rise_ok    = run & rise_event & ~fbl_busy;
  assign fall_ok    = run & fall_event & ~rbl_busy;
  assign drive_rise = drive & ~drive_q;
  assign drive_fall = ~drive & drive_q;

  assign sd_src = sd_input_en & ~shutdown_in_n;

  assign ld_xfer  = (ld_state == cogc_pkg::LD_WAIT) & rise_ok;
  assign ld_clear = ~module_enable_flag | ld_xfer;

  // ****************************************
  // Read mux
  // ****************************************
  assign rd_byte =
      hit_con0 ? {module_enable_flag, buffer_load_request, 1'b0,
                  clock_source_field, output_mode_field}
    : hit_con1 ? {rise_deadband_source, fall_deadband_source,
                  2'b00, out_polarity}
    : hit_rph  ? 8'(cnt_reg.rise_phase)
    : hit_fph  ? 8'(cnt_reg.fall_phase)
    : hit_rbl  ? 8'(cnt_reg.rise_blank)
    : hit_fbl  ? 8'(cnt_reg.fall_blank)
    : hit_rdb  ? 8'(cnt_reg.rise_db)
    : hit_fdb  ? 8'(cnt_reg.fall_db)
    : hit_sd   ? {shutdown_active_flag, auto_restart_enable,
                  ovr_bd, ovr_ac, 1'b0, sd_input_en}
    : hit_str  ? {static_level, steer_en}
    : hit_sts  ? {2'b00, sd_src, sd_hold, b_on, a_on, drive, bad_cfg}
    : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_enable_flag <= 1'b0;
      clock_source_field <= 2'b00;
      output_mode_field  <= 3'b000;
    end else if (wr && hit_con0) begin
      module_enable_flag <= wbyte[cogc_pkg::EN_BIT];
      clock_source_field <= wbyte[cogc_pkg::CS_LSB +: 2];
      output_mode_field  <= wbyte[cogc_pkg::MD_LSB +: 3];
    end
  end

  // A fresh request in the clearing cycle survives: set wins over clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_load_request <= 1'b0;
    end else if (wr && hit_con0 && wbyte[cogc_pkg::LD_BIT]) begin
      buffer_load_request <= 1'b1;
    end else if (ld_clear) begin
      buffer_load_request <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_deadband_source <= 1'b0;
      fall_deadband_source <= 1'b0;
      out_polarity         <= 4'h0;
    end else if (wr && hit_con1) begin
      rise_deadband_source <= wbyte[cogc_pkg::RDBS_BIT];
      fall_deadband_source <= wbyte[cogc_pkg::FDBS_BIT];
      out_polarity         <= wbyte[cogc_pkg::POL_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (wr) begin
      if (hit_rph) cnt_reg.rise_phase <= wbyte[CW-1:0];
      if (hit_fph) cnt_reg.fall_phase <= wbyte[CW-1:0];
      if (hit_rbl) cnt_reg.rise_blank <= wbyte[CW-1:0];
      if (hit_fbl) cnt_reg.fall_blank <= wbyte[CW-1:0];
      if (hit_rdb) cnt_reg.rise_db    <= wbyte[CW-1:0];
      if (hit_fdb) cnt_reg.fall_db    <= wbyte[CW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_restart_enable <= 1'b0;
      ovr_ac              <= 2'b00;
      ovr_bd              <= 2'b00;
      sd_input_en         <= 1'b0;
      steer_en            <= 4'h0;
      static_level        <= 4'h0;
    end else if (wr) begin
      if (hit_sd) begin
        auto_restart_enable <= wbyte[cogc_pkg::ARS_BIT];
        ovr_ac              <= wbyte[cogc_pkg::OVAC_LSB +: 2];
        ovr_bd              <= wbyte[cogc_pkg::OVBD_LSB +: 2];
        sd_input_en         <= wbyte[cogc_pkg::SDEN_BIT];
      end
      if (hit_str) begin
        steer_en     <= wbyte[cogc_pkg::STEER_LSB +: 4];
        static_level <= wbyte[cogc_pkg::LVL_LSB +: 4];
      end
    end
  end

  // ****************************************
  // Shutdown
  // ****************************************
  // A level on a selected input always sets the flag; software or the
  // restart logic can clear it only once that input is false.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_active_flag <= 1'b0;
    end else if (sd_src) begin
      shutdown_active_flag <= 1'b1;
    end else if (wr && hit_sd) begin
      shutdown_active_flag <= wbyte[cogc_pkg::ASE_BIT];
    end else if (auto_restart_enable) begin
      shutdown_active_flag <= 1'b0;
    end
  end

  // Overrides hold until the first rising event after shutdown clears.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_hold <= 1'b1;
    end else if (shutdown_active_flag || sd_src) begin
      sd_hold <= 1'b1;
    end else if (rise_ok) begin
      sd_hold <= 1'b0;
    end
  end

  // ****************************************
  // Buffer load sequence
  // ****************************************
  always_comb begin
    case (ld_state)
      cogc_pkg::LD_IDLE:
        next_ld_state = (buffer_load_request && module_enable_flag)
                      ? cogc_pkg::LD_WAIT : cogc_pkg::LD_IDLE;
      cogc_pkg::LD_WAIT:
        next_ld_state = ld_clear ? cogc_pkg::LD_IDLE : cogc_pkg::LD_WAIT;
      default:
        next_ld_state = cogc_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state <= cogc_pkg::LD_IDLE;
    end else begin
      ld_state <= next_ld_state;
    end
  end

  // Buffers track the registers while disabled, so no request is needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_buf <= '0;
    end else if (!module_enable_flag || ld_xfer) begin
      cnt_buf <= cnt_reg;
    end
  end

  // ****************************************
  // Timing stages
  // ****************************************
  cogc_clk_tick u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .sel       (clock_source_field),
    .fast_tick (fast_osc_tick),
    .tick      (mod_tick)
  );

  cogc_delay #(.CNT_W(CW)) u_rph (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (rise_ok), .count (cnt_buf.rise_phase),
    .fast (1'b0), .tick (mod_tick), .busy (), .done (rph_done)
  );

  cogc_delay #(.CNT_W(CW)) u_fph (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (fall_ok), .count (cnt_buf.fall_phase),
    .fast (1'b0), .tick (mod_tick), .busy (), .done (fph_done)
  );

  cogc_delay #(.CNT_W(CW)) u_rbl (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (rise_ok), .count (cnt_buf.rise_blank),
    .fast (1'b0), .tick (mod_tick), .busy (rbl_busy), .done ()
  );

  cogc_delay #(.CNT_W(CW)) u_fbl (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (fall_ok), .count (cnt_buf.fall_blank),
    .fast (1'b0), .tick (mod_tick), .busy (fbl_busy), .done ()
  );

  cogc_delay #(.CNT_W(CW)) u_rdb (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (drive_rise), .count (cnt_buf.rise_db),
    .fast (rise_deadband_source),
    .tick (mod_tick), .busy (), .done (rdb_done)
  );

  cogc_delay #(.CNT_W(CW)) u_fdb (
    .pclk (pclk), .presetn (presetn), .clr (~run),
    .trig (drive_fall), .count (cnt_buf.fall_db),
    .fast (fall_deadband_source),
    .tick (mod_tick), .busy (), .done (fdb_done)
  );

  // ****************************************
  // Primary drive and dead-band
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive   <= 1'b0;
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive;
      if (!run) begin
        drive <= 1'b0;
      end else if (fph_done) begin
        drive <= 1'b0;
      end else if (rph_done) begin
        drive <= 1'b1;
      end
    end
  end

  // Each side turns off at once and on only after its dead-band.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_on <= 1'b0;
      b_on <= 1'b0;
    end else begin
      a_on <= drive & ~drive_fall & (a_on | rdb_done);
      b_on <= run & ~drive & ~drive_rise & (b_on | fdb_done);
    end
  end

  // Push-pull alternation and synchronous steering follow each period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pp_phase  <= 1'b0;
      steer_act <= 4'h0;
    end else if (!run) begin
      pp_phase  <= 1'b0;
      steer_act <= steer_en;
    end else if (drive_rise) begin
      pp_phase  <= ~pp_phase;
      steer_act <= steer_en;
    end
  end

  // ****************************************
  // Output modes, polarity and overrides
  // ****************************************
  logic [3:0] raw;
  logic [3:0] steer_sel;
  logic [3:0] pwm_lvl;
  cogc_pkg::cogc_pins_t next_pins;

  assign steer_sel = (output_mode_field == cogc_pkg::MD_SSTEER)
                   ? steer_act : steer_en;

  // Bit order is {D, C, B, A}; values here are active-high.
  always_comb begin
    case (output_mode_field)
      cogc_pkg::MD_PUSH:
        raw = {a_on & pp_phase, a_on & ~pp_phase,
               a_on & pp_phase, a_on & ~pp_phase};
      cogc_pkg::MD_HALF:
        raw = {b_on, a_on, b_on, a_on};
      cogc_pkg::MD_REV_FB:
        raw = {1'b0, run, a_on, 1'b0};
      cogc_pkg::MD_FWD_FB:
        raw = {a_on, 1'b0, 1'b0, run};
      cogc_pkg::MD_STEER,
      cogc_pkg::MD_SSTEER:
        raw = (steer_sel & {4{a_on}})
            | (~steer_sel & static_level);
      default:
        raw = 4'h0;
    endcase
  end

  assign pwm_lvl = raw ^ out_polarity;

  // Forced levels ignore polarity; the inactive override honours it.
  function automatic logic [1:0] ovr_pin(input logic [1:0] code,
                                         input logic pol);
    case (code)
      cogc_pkg::OV_TRI:  ovr_pin = 2'b00;
      cogc_pkg::OV_LOW:  ovr_pin = 2'b01;
      cogc_pkg::OV_HIGH: ovr_pin = 2'b11;
      default:           ovr_pin = {pol, 1'b1};
    endcase
  endfunction : ovr_pin

  always_comb begin
    logic [1:0] ov;
    ov        = 2'b00;
    next_pins = '0;
    for (int i = 0; i < 4; i++) begin
      ov = ovr_pin(i[0] ? ovr_bd : ovr_ac, out_polarity[i]);
      if (!module_enable_flag) begin
        next_pins.level[i] = out_polarity[i];
        next_pins.oe[i]    = 1'b0;
      end else if (bad_cfg) begin
        next_pins.level[i] = out_polarity[i];
        next_pins.oe[i]    = 1'b1;
      end else if (sd_hold) begin
        next_pins.level[i] = ov[1];
        next_pins.oe[i]    = ov[0];
      end else begin
        next_pins.level[i] = pwm_lvl[i];
        next_pins.oe[i]    = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins <= '0;
    end else begin
      pins <= next_pins;
    end
  end

endmodule : cogc_core

/* File: cogc_delay.sv */
// Programmable delay stage used for phase, blanking and dead-band timing.
// Assumes trig is a one-cycle pulse; a zero count passes the trigger straight.
`timescale 1ns/1ns
module cogc_delay #(
  parameter int CNT_W = 6
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clr,
  input  wire logic             trig,
  input  wire logic [CNT_W-1:0] count,
  input  wire logic             fast,
  input  wire logic             tick,
  output logic                  busy,
  output logic                  done
);

  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("cogc_delay: CNT_W must be 1 to 16");
  end

  logic [CNT_W-1:0] remain;
  logic             step;
  logic             expire;

  // The fast path stands in for the delay chain and steps every pclk.
  assign step   = busy & (fast | tick);
  assign expire = step & (remain == CNT_W'(1));
  assign done   = (trig & (count == '0)) | expire;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy   <= 1'b0;
      remain <= '0;
    end else if (clr) begin
      busy   <= 1'b0;
      remain <= '0;
    end else if (trig && count != '0) begin
      busy   <= 1'b1;
      remain <= count;
    end else if (step) begin
      busy   <= ~expire;
      remain <= remain - CNT_W'(1);
    end
  end

endmodule : cogc_delay

/* File: cogc_pkg.sv */
// Constants, register map and carrier types of the output generator.
// Assumes one APB clock domain and 32-bit aligned register words.
package cogc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFF_CON0   = 8'h00;
  localparam logic [7:0] OFF_CON1   = 8'h04;
  localparam logic [7:0] OFF_RPHASE = 8'h08;
  localparam logic [7:0] OFF_FPHASE = 8'h0c;
  localparam logic [7:0] OFF_RBLANK = 8'h10;
  localparam logic [7:0] OFF_FBLANK = 8'h14;
  localparam logic [7:0] OFF_RDB    = 8'h18;
  localparam logic [7:0] OFF_FDB    = 8'h1c;
  localparam logic [7:0] OFF_SDCTL  = 8'h20;
  localparam logic [7:0] OFF_STEER  = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int EN_BIT    = 7;
  localparam int LD_BIT    = 6;
  localparam int CS_LSB    = 3;
  localparam int MD_LSB    = 0;
  localparam int RDBS_BIT  = 7;
  localparam int FDBS_BIT  = 6;
  localparam int POL_LSB   = 0;
  localparam int ASE_BIT   = 7;
  localparam int ARS_BIT   = 6;
  localparam int OVBD_LSB  = 4;
  localparam int OVAC_LSB  = 2;
  localparam int SDEN_BIT  = 0;
  localparam int LVL_LSB   = 4;
  localparam int STEER_LSB = 0;
  localparam int COUNT_W   = 6;
  localparam int FOSC4_DIV = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [1:0] {
    CS_FOSC4 = 2'b00,
    CS_FOSC  = 2'b01,
    CS_FAST  = 2'b10,
    CS_RSVD  = 2'b11
  } cogc_clk_src_t;

  typedef enum logic [2:0] {
    MD_STEER  = 3'b000,
    MD_SSTEER = 3'b001,
    MD_FWD_FB = 3'b010,
    MD_REV_FB = 3'b011,
    MD_HALF   = 3'b100,
    MD_PUSH   = 3'b101
  } cogc_mode_t;

  typedef enum logic [1:0] {
    OV_INACT = 2'b00,
    OV_TRI   = 2'b01,
    OV_LOW   = 2'b10,
    OV_HIGH  = 2'b11
  } cogc_ovr_t;

  typedef enum logic [1:0] {
    LD_IDLE = 2'b01,
    LD_WAIT = 2'b10
  } cogc_ld_state_t;

  typedef struct packed {
    logic [COUNT_W-1:0] rise_phase;
    logic [COUNT_W-1:0] fall_phase;
    logic [COUNT_W-1:0] rise_blank;
    logic [COUNT_W-1:0] fall_blank;
    logic [COUNT_W-1:0] rise_db;
    logic [COUNT_W-1:0] fall_db;
  } cogc_counts_t;

  // Bit 0 is output A, bit 3 is output D.
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] oe;
  } cogc_pins_t;

endpackage : cogc_pkg

/* File: cogc_stage.sv */
// Switch stage model on the four outputs.
// Assumes a gate pull-down, so a released output reads low.
`timescale 1ns/1ns
module cogc_stage (
  input  wire cogc_pkg::cogc_pins_t pins,
  input  wire logic                 fault,
  output logic                      shutdown_in_n,
  output logic [3:0]                gate
);
  assign gate = pins.level & pins.oe;
  assign shutdown_in_n = !fault;
endmodule : cogc_stage

/* File: tb_complementary_output_gen_control.sv */
// Self-checking bench for the output generator controls.
// Assumes the switch stage model and the bound port checker.
`timescale 1ns/1ns
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_complementary_output_gen_control;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic                 rise_event = 1'b0;
  logic                 fault = 1'b0;
  logic                 shutdown_in_n;
  logic                 pready;
  logic                 pslverr;
  logic                 err;
  logic [31:0]          prdata;
  logic [31:0]          rd;
  logic [3:0]           gate;
  logic [7:0]           rsv [2] = '{8'h9c, 8'h8e};
  cogc_pkg::cogc_pins_t pins;
  int                   failures = 0;
  int                   total_checks = 0;
  always #20 pclk = ~pclk;
  cogc_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fast_osc_tick(1'b0), .rise_event, .fall_event(1'b0),
    .shutdown_in_n, .pins);
  cogc_stage stage (.pins, .fault, .shutdown_in_n, .gate);
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00);
    `CHK(n, {24'h0, e}, rd)
  endtask : chk_rd
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_rd(cogc_pkg::OFF_CON0, 8'h00, "con0 reset");
    chk_rd(cogc_pkg::OFF_CON1, 8'h00, "con1 reset");
    chk_rd(8'h3c, 8'h00, "unmapped");
    `CHK("unmapped err", 1'b1, err)
    apb(1'b1, cogc_pkg::OFF_RDB, 8'h03);
    apb(1'b1, cogc_pkg::OFF_SDCTL, 8'h80);
    apb(1'b1, cogc_pkg::OFF_CON1, 8'hff);
    chk_rd(cogc_pkg::OFF_CON1, 8'hcf, "con1");
    `CHK("off oe", 4'h0, pins.oe)
    `CHK("off level", 4'hf, pins.level)
    apb(1'b1, cogc_pkg::OFF_CON0, 8'h40);
    chk_rd(cogc_pkg::OFF_CON0, 8'h00, "load off");
    $display("test setup done");
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, cogc_pkg::OFF_CON0, 8'h80 | m[7:0] | (8'(m % 3) << 3));
      chk_rd(cogc_pkg::OFF_CON0, 8'h80 | m[7:0] | (8'(m % 3) << 3), "mode");
    end
    foreach (rsv[i]) begin
      apb(1'b1, cogc_pkg::OFF_CON0, rsv[i]);
      repeat (4) @(posedge pclk);
      `CHK("rsvd oe", 4'hf, pins.oe)
      `CHK("rsvd level", 4'hf, pins.level)
    end
    $display("test modes done");
    apb(1'b1, cogc_pkg::OFF_CON0, 8'h8c);
    apb(1'b1, cogc_pkg::OFF_SDCTL, 8'h00);
    repeat (4) @(posedge pclk);
    `CHK("on gate", 4'hf, gate)
    apb(1'b1, cogc_pkg::OFF_CON0, 8'hcc);
    repeat (4) @(posedge pclk);
    chk_rd(cogc_pkg::OFF_CON0, 8'hcc, "load held");
    rise_event <= 1'b1;
    @(posedge pclk);
    rise_event <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_rd(cogc_pkg::OFF_CON0, 8'h8c, "load done");
    @(posedge pclk);
    `CHK("half gate", 4'ha, gate)
    $display("test load done");
    apb(1'b1, cogc_pkg::OFF_SDCTL, 8'h01);
    fault <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("fault gate", 4'hf, gate)
    chk_rd(cogc_pkg::OFF_SDCTL, 8'h81, "fault flag");
    $display("test shutdown done");
    print_verdict();
  end
endmodule : tb_complementary_output_gen_control
